//--- rtl/smsi_pkg.sv
// smsi_pkg: constants shared by both ends of the serial segment link
// assumes a 50 MHz mclk on both ends and a slower shared link clock
package smsi_pkg;

   // core clock period
   localparam int CLK_PERIOD_NS = 20;

   // segment geometry
   localparam logic [3:0] SEG_LAST   = 4'h9;   // index of last bit in a segment
   localparam logic [3:0] REP_LAST   = 4'h9;   // last repeat of a 10 Mbps byte group
   localparam logic [3:0] POS_RESET  = 4'h9;   // position after reset, next bit is 0
   localparam logic [3:0] REP_RESET  = 4'h0;

   // receive segment bit positions (device to mac)
   localparam int RX_BIT_CRS  = 0;
   localparam int RX_BIT_DV   = 1;
   // transmit segment bit positions (mac to device)
   localparam int TX_BIT_ERR  = 0;
   localparam int TX_BIT_EN   = 1;
   // data byte occupies bits 2..9 in both directions
   localparam int SEG_DATA_LO = 2;

   // status byte sent when no receive data is valid
   localparam logic [7:0] STATUS_BASE   = 8'h80;
   localparam int         STATUS_BIT_FAST = 1;

   // line latencies
   localparam int LAT_CRS_NS  = 250;
   localparam int LAT_TX_NS   = 250;
   localparam int LAT_RMII_NS = 200;
   localparam logic [3:0] LAT_CRS_CYC  = 4'((LAT_CRS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] LAT_TX_CYC   = 4'((LAT_TX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] LAT_RMII_CYC = 4'((LAT_RMII_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // configuration strap codes {strap_2, strap_1, strap_0}
   localparam logic [2:0] STRAP_SMII = 3'h4;
   localparam logic [2:0] STRAP_RMII = 3'h2;

   // strap capture waits for the synchroniser to fill
   localparam logic [1:0] CAP_SAMPLE = 2'h2;
   localparam logic [1:0] CAP_DONE   = 2'h3;

   // interface mode of the device end
   typedef enum logic [1:0] {
      SMSI_MODE_MII,
      SMSI_MODE_RMII,
      SMSI_MODE_SMII
   } smsi_mode_e;

endpackage : smsi_pkg

//--- rtl/smsi_if.sv
// smsi_if: pins of the serial segment link between device and mac
// assumes the bench drives serial_ref_clock; both ends only sample it
`timescale 1ns/1ps
interface smsi_if;
   logic serial_ref_clock;   // shared reference clock
   logic sync;               // segment start, on the device tx-enable pin
   logic txd;                // mac to device serial data
   logic rxd;                // device to mac serial data

   modport dev (
      input  serial_ref_clock,
      input  sync,
      input  txd,
      output rxd
   );

   modport mac (
      input  serial_ref_clock,
      input  rxd,
      output sync,
      output txd
   );
endinterface : smsi_if

//--- rtl/smsi_phy.sv
// smsi_phy: device end of the serial segment link with strap mode select
// assumes the link clock is slow enough to be oversampled by mclk
`timescale 1ns/1ps
module smsi_phy (
   input  wire logic        mclk,            // core clock
   input  wire logic        sys_rst,         // async reset, active high
   smsi_if.dev              link,            // serial link pins
   input  wire logic        config_strap_2,  // mode strap pin 2
   input  wire logic        config_strap_1,  // mode strap pin 1
   input  wire logic        config_strap_0,  // mode strap pin 0
   input  wire logic        speed_10,        // 1 = 10 Mbps segment repetition
   input  wire logic        line_rx_active,  // valid data on line receive pair
   input  wire logic [7:0]  line_rx_byte,    // byte received from the line
   input  wire logic        line_rx_stb,     // line_rx_byte is new
   output logic             line_tx_active,  // drive line transmit pair
   output logic [7:0]       line_tx_byte,    // byte to send on the line
   output logic             line_tx_err,     // error flag with line_tx_byte
   output logic             line_tx_stb,     // line_tx_byte is new
   output logic             carrier_sense,   // carrier sense, serial mode
   output logic             rmii_rx_valid,   // receive valid, reduced-pin mode
   output logic             mii_tx_en,       // tx-enable qualifier, nibble mode
   output logic             smii_mode        // serial mode selected
);

   // ---------------------------------------------------------------
   // pin synchronisers: straps, link clock, sync and txd
   // ---------------------------------------------------------------
   logic [5:0] pin_raw;
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic       ref_prev_q;

   assign pin_raw = {config_strap_2, config_strap_1, config_strap_0,
                     link.serial_ref_clock, link.sync, link.txd};

   // two flops per pin before any logic reads it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_q   <= 6'h00;
         pin_s2_q   <= 6'h00;
         ref_prev_q <= 1'b0;
      end else begin
         pin_s1_q   <= pin_raw;
         pin_s2_q   <= pin_s1_q;
         ref_prev_q <= pin_s2_q[2];
      end
   end

   logic [2:0] strap_s;
   logic       ref_s;
   logic       sync_s;
   logic       txd_s;
   logic       ref_rise;
   logic       ref_fall;

   assign strap_s  = pin_s2_q[5:3];
   assign ref_s    = pin_s2_q[2];
   assign sync_s   = pin_s2_q[1];
   assign txd_s    = pin_s2_q[0];
   assign ref_rise = ref_s & ~ref_prev_q;
   assign ref_fall = ~ref_s & ref_prev_q;

   // ---------------------------------------------------------------
   // strap capture once after reset release
   // ---------------------------------------------------------------
   logic [1:0]             cap_cnt_q;
   smsi_pkg::smsi_mode_e   mode_q;
   smsi_pkg::smsi_mode_e   strap_mode;

   assign strap_mode = (strap_s == smsi_pkg::STRAP_SMII) ? smsi_pkg::SMSI_MODE_SMII :
                       (strap_s == smsi_pkg::STRAP_RMII) ? smsi_pkg::SMSI_MODE_RMII :
                       smsi_pkg::SMSI_MODE_MII;

   // mode is fixed from the straps seen after the synchroniser filled
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_cnt_q <= 2'h0;
         mode_q    <= smsi_pkg::SMSI_MODE_MII;
      end else if (cap_cnt_q != smsi_pkg::CAP_DONE) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
         if (cap_cnt_q == smsi_pkg::CAP_SAMPLE) begin
            mode_q <= strap_mode;
         end
      end
   end

   logic is_smii;
   logic is_rmii;

   assign is_smii   = (mode_q == smsi_pkg::SMSI_MODE_SMII);
   assign is_rmii   = (mode_q == smsi_pkg::SMSI_MODE_RMII);
   assign smii_mode = is_smii;
   // the pin qualifies transmit only in nibble mode, never in serial or reduced-pin mode
   assign mii_tx_en = (mode_q == smsi_pkg::SMSI_MODE_MII) & sync_s;

   // ---------------------------------------------------------------
   // segment position, framed by sync
   // ---------------------------------------------------------------
   logic [3:0] pos_q;
   logic [3:0] pos_nx;
   logic [3:0] fall_idx;
   logic       sync_seen;

   // in serial mode the tx-enable pin carries sync
   assign sync_seen = is_smii & sync_s;
   // bit zero is the one sampled together with sync
   assign pos_nx    = sync_seen ? 4'h0 :
                      (pos_q == smsi_pkg::SEG_LAST) ? 4'h0 : pos_q + 4'h1;
   assign fall_idx  = (pos_q == smsi_pkg::SEG_LAST) ? 4'h0 : pos_q + 4'h1;

   // ---------------------------------------------------------------
   // transmit segment capture on link rising edges
   // ---------------------------------------------------------------
   logic [9:0] tx_seg_q;
   logic       seg_done_q;
   logic [3:0] rep_q;
   logic       group_first;

   assign group_first = ~speed_10 | (rep_q == smsi_pkg::REP_RESET);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_q      <= smsi_pkg::POS_RESET;
         tx_seg_q   <= 10'h000;
         seg_done_q <= 1'b0;
      end else begin
         seg_done_q <= 1'b0;
         if (is_smii && ref_rise) begin
            pos_q            <= pos_nx;
            tx_seg_q[pos_nx] <= txd_s;
            seg_done_q       <= (pos_nx == smsi_pkg::SEG_LAST);
         end
      end
   end

   // repeat counter: one group of ten segments per byte at 10 Mbps
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rep_q <= smsi_pkg::REP_RESET;
      end else if (seg_done_q) begin
         if (!speed_10 || rep_q == smsi_pkg::REP_LAST) begin
            rep_q <= smsi_pkg::REP_RESET;
         end else begin
            rep_q <= rep_q + 4'h1;
         end
      end
   end

   // decode a finished segment, one per group at 10 Mbps
   logic tx_en_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_en_q      <= 1'b0;
         line_tx_byte <= 8'h00;
         line_tx_err  <= 1'b0;
         line_tx_stb  <= 1'b0;
      end else begin
         line_tx_stb <= 1'b0;
         if (!is_smii) begin
            tx_en_q <= 1'b0;
         end else if (seg_done_q && group_first) begin
            tx_en_q     <= tx_seg_q[smsi_pkg::TX_BIT_EN];
            line_tx_err <= tx_seg_q[smsi_pkg::TX_BIT_ERR];
            if (tx_seg_q[smsi_pkg::TX_BIT_EN]) begin
               line_tx_byte <= tx_seg_q[9:smsi_pkg::SEG_DATA_LO];
               line_tx_stb  <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // latency timers: crs, line transmit, reduced-pin receive valid
   // ---------------------------------------------------------------
   logic [2:0] dly_in;
   logic [2:0] dly_q;
   logic [3:0] dly_lim [3];

   assign dly_in[0]  = is_smii & line_rx_active;
   assign dly_in[1]  = is_smii & tx_en_q;
   assign dly_in[2]  = is_rmii & line_rx_active;
   assign dly_lim[0] = smsi_pkg::LAT_CRS_CYC;
   assign dly_lim[1] = smsi_pkg::LAT_TX_CYC;
   assign dly_lim[2] = smsi_pkg::LAT_RMII_CYC;

   // output follows its input once the input has held for the latency
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_dly
         logic [3:0] cnt_q;
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               cnt_q     <= 4'h0;
               dly_q[gi] <= 1'b0;
            end else if (dly_in[gi] == dly_q[gi]) begin
               cnt_q <= 4'h0;
            end else if (cnt_q == dly_lim[gi] - 4'h1) begin
               cnt_q     <= 4'h0;
               dly_q[gi] <= dly_in[gi];
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   endgenerate

   assign carrier_sense  = dly_q[0];
   assign line_tx_active = dly_q[1];
   assign rmii_rx_valid  = dly_q[2];

   // ---------------------------------------------------------------
   // receive byte holding register; a new byte wins over the take
   // ---------------------------------------------------------------
   logic [7:0] rx_hold_q;
   logic       rx_pend_q;
   logic       seg_load;
   logic       rx_take;

   assign seg_load = is_smii & ref_fall & (pos_q == smsi_pkg::SEG_LAST);
   assign rx_take  = seg_load & group_first & rx_pend_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_hold_q <= 8'h00;
         rx_pend_q <= 1'b0;
      end else begin
         rx_pend_q <= line_rx_stb | (rx_pend_q & ~rx_take);
         if (line_rx_stb) begin
            rx_hold_q <= line_rx_byte;
         end
      end
   end

   // ---------------------------------------------------------------
   // receive segment build and shift-out on link falling edges
   // ---------------------------------------------------------------
   logic [9:0] rx_seg_q;
   logic [9:0] rx_seg_new;
   logic [9:0] rx_seg_use;
   logic [7:0] status_byte;
   logic       rxd_q;

   // speed flag widened before the shift so only one bit can be set
   assign status_byte = smsi_pkg::STATUS_BASE |
                        ({7'h00, ~speed_10} << smsi_pkg::STATUS_BIT_FAST);
   assign rx_seg_new  = {rx_pend_q ? rx_hold_q : status_byte,
                         rx_pend_q, dly_q[0]};
   // at 10 Mbps only the first segment of a group takes new content
   assign rx_seg_use  = group_first ? rx_seg_new : rx_seg_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_seg_q <= 10'h000;
         rxd_q    <= 1'b0;
      end else if (!is_smii) begin
         rxd_q <= 1'b0;
      end else if (seg_load) begin
         rx_seg_q <= rx_seg_use;
         rxd_q    <= rx_seg_use[0];
      end else if (ref_fall) begin
         rxd_q <= rx_seg_q[fall_idx];
      end
   end

   assign link.rxd = rxd_q;

endmodule : smsi_phy

//--- rtl/smsi_mac.sv
// smsi_mac: mac end of the serial segment link, makes sync and framing
// assumes the link clock is slow enough to be oversampled by mclk
`timescale 1ns/1ps
module smsi_mac (
   input  wire logic        mclk,       // core clock
   input  wire logic        sys_rst,    // async reset, active high
   smsi_if.mac              link,       // serial link pins
   input  wire logic        speed_10,   // 1 = 10 Mbps segment repetition
   input  wire logic        tx_valid,   // tx_byte offered
   input  wire logic [7:0]  tx_byte,    // byte to transmit
   input  wire logic        tx_err,     // error flag with tx_byte
   output logic             tx_take,    // tx_byte accepted this cycle
   output logic [7:0]       rx_byte,    // received byte
   output logic             rx_stb,     // rx_byte is new
   output logic             rx_crs,     // carrier sense from device
   output logic [7:0]       rx_status   // status byte from idle segments
);

   // two-flop synchronisers for link clock and rxd
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic       ref_prev_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_q   <= 2'h0;
         pin_s2_q   <= 2'h0;
         ref_prev_q <= 1'b0;
      end else begin
         pin_s1_q   <= {link.serial_ref_clock, link.rxd};
         pin_s2_q   <= pin_s1_q;
         ref_prev_q <= pin_s2_q[1];
      end
   end

   logic       ref_rise;
   logic       ref_fall;
   logic [3:0] pos_q;
   logic [3:0] pos_nx;

   assign ref_rise = pin_s2_q[1] & ~ref_prev_q;
   assign ref_fall = ~pin_s2_q[1] & ref_prev_q;
   assign pos_nx   = (pos_q == smsi_pkg::SEG_LAST) ? 4'h0 : pos_q + 4'h1;

   // transmit: sync once per ten clocks, repeat content at 10 Mbps
   logic [9:0] tx_seg_q;
   logic [9:0] tx_seg_new;
   logic [3:0] tx_rep_q;
   logic       tx_first;
   logic       seg_load;
   logic       sync_q;
   logic       txd_q;

   assign seg_load   = ref_fall & (pos_nx == 4'h0);
   assign tx_first   = ~speed_10 | (tx_rep_q == smsi_pkg::REP_RESET);
   assign tx_seg_new = tx_first ? {tx_byte, tx_valid, tx_valid & tx_err} : tx_seg_q;
   assign tx_take    = seg_load & tx_first & tx_valid;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_q    <= smsi_pkg::POS_RESET;
         tx_seg_q <= 10'h000;
         tx_rep_q <= smsi_pkg::REP_RESET;
         sync_q   <= 1'b0;
         txd_q    <= 1'b0;
      end else begin
         if (ref_rise) begin
            pos_q <= pos_nx;
         end
         if (ref_fall) begin
            sync_q <= (pos_nx == 4'h0);
            txd_q  <= (pos_nx == 4'h0) ? tx_seg_new[0] : tx_seg_q[pos_nx];
         end
         if (seg_load) begin
            tx_seg_q <= tx_seg_new;
            tx_rep_q <= (!speed_10 || tx_rep_q == smsi_pkg::REP_LAST) ?
                        smsi_pkg::REP_RESET : tx_rep_q + 4'h1;
         end
      end
   end

   assign link.sync = sync_q;
   assign link.txd  = txd_q;

   // receive: shift bits by position, decode first of each group
   logic [9:0] rx_seg_q;
   logic       rx_done_q;
   logic [3:0] rx_rep_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_seg_q  <= 10'h000;
         rx_done_q <= 1'b0;
         rx_rep_q  <= smsi_pkg::REP_RESET;
         rx_byte   <= 8'h00;
         rx_stb    <= 1'b0;
         rx_crs    <= 1'b0;
         rx_status <= 8'h00;
      end else begin
         rx_stb    <= 1'b0;
         rx_done_q <= ref_rise & (pos_nx == smsi_pkg::SEG_LAST);
         if (ref_rise) begin
            rx_seg_q[pos_nx] <= pin_s2_q[0];
         end
         if (rx_done_q) begin
            rx_rep_q <= (!speed_10 || rx_rep_q == smsi_pkg::REP_LAST) ?
                        smsi_pkg::REP_RESET : rx_rep_q + 4'h1;
            if (!speed_10 || rx_rep_q == smsi_pkg::REP_RESET) begin
               rx_crs <= rx_seg_q[smsi_pkg::RX_BIT_CRS];
               if (rx_seg_q[smsi_pkg::RX_BIT_DV]) begin
                  rx_byte <= rx_seg_q[9:smsi_pkg::SEG_DATA_LO];
                  rx_stb  <= 1'b1;
               end else begin
                  rx_status <= rx_seg_q[9:smsi_pkg::SEG_DATA_LO];
               end
            end
         end
      end
   end

endmodule : smsi_mac

//--- verif/smsi_monitor.sv
// smsi_monitor: timing and framing checks on the link pins shared by both ends
// assumes mclk runs 8 cycles per link bit and samples all four link pins
`timescale 1ns/1ps
module smsi_monitor (
   input wire logic mclk,              // core clock
   input wire logic sys_rst,           // async reset, active high
   input wire logic serial_ref_clock,  // shared link clock
   input wire logic sync,              // segment start
   input wire logic txd,               // mac to device data
   input wire logic rxd                // device to mac data
);
   logic [6:0] gap_q;      // mclk since last sync rise
   logic       seen_q;     // one sync rise seen
   logic       algn_q;     // sync seen at a link rise
   logic [3:0] pos_q;      // bit position at last link rise
   logic [9:0] seg_q;      // receive segment, bit 0 at the bottom
   logic [1:0] segs_q;     // whole segments captured, saturating
   logic       done_q;     // segment just completed

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // shadow of the segment framing, sampled on link rising edges
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_q  <= 7'h00;
         seen_q <= 1'b0;
         algn_q <= 1'b0;
         pos_q  <= 4'h0;
         seg_q  <= 10'h000;
         segs_q <= 2'h0;
         done_q <= 1'b0;
      end else begin
         gap_q  <= $rose(sync) ? 7'h00 : gap_q + 7'h01;
         seen_q <= seen_q | $rose(sync);
         done_q <= $rose(serial_ref_clock) & ~sync & (pos_q == 4'h8) & algn_q;
         if ($rose(serial_ref_clock)) begin
            seg_q  <= {rxd, seg_q[9:1]};
            pos_q  <= sync ? 4'h0 : pos_q + 4'h1;
            algn_q <= algn_q | sync;
         end
         if (done_q && segs_q != 2'h3) begin
            segs_q <= segs_q + 2'h1;
         end
      end
   end

   a_sync_pulse_width: assert property ($rose(sync) |-> sync[*7] ##[1:2] !sync)
      else $error("sync pulse not one link period wide");
   a_sync_pulse_period: assert property ($rose(sync) && seen_q |-> gap_q >= 7'h4E && gap_q <= 7'h50)
      else $error("sync pulses not ten link periods apart");
   a_sync_hold_rise: assert property ($rose(serial_ref_clock) |=> $stable(sync)[*2])
      else $error("sync moved near a link rising edge");
   a_txd_hold_rise: assert property ($rose(serial_ref_clock) |=> $stable(txd)[*2])
      else $error("txd moved near a link rising edge");
   a_rxd_hold_rise: assert property ($rose(serial_ref_clock) |=> $stable(rxd)[*2])
      else $error("rxd moved near a link rising edge");
   a_link_quiet_release: assert property ($fell(sys_rst) |-> !sync && !txd && !rxd)
      else $error("link pins active at reset release");
   a_segment_ten_bits: assert property ($rose(serial_ref_clock) && algn_q |-> sync == (pos_q == 4'h9))
      else $error("sync not every tenth link bit");
   a_status_byte_form: assert property (done_q && segs_q[1] && !seg_q[1] && seg_q[9]
                                        |-> seg_q[8:4] == 5'h00 && !seg_q[2])
      else $error("idle segment status byte malformed");

   c_sync_seen: cover property ($rose(sync));
   c_data_segment: cover property (done_q && seg_q[1]);
   c_idle_segment: cover property (done_q && !seg_q[1] && seg_q[9]);
endmodule : smsi_monitor

//--- verif/testbench.sv
// testbench: joins both link ends and drives and checks their user sides
// assumes package, interface, both ends and the monitor are compiled first
`timescale 1ns/1ps
module testbench;
   logic       mclk;        // core clock
   logic       sys_rst;     // async reset
   logic [2:0] straps;      // {strap_2, strap_1, strap_0}
   logic       speed_10;    // 10 Mbps repetition on both ends
   logic       rx_act;      // line receive activity
   logic [7:0] rx_in;       // byte from the line
   logic       rx_in_stb;   // rx_in is new
   logic       tx_valid;    // mac byte offered
   logic [7:0] tx_byte;     // mac byte
   logic       tx_err;      // mac error flag
   logic       line_tx_active, line_tx_err, line_tx_stb, carrier_sense;
   logic       rmii_rx_valid, mii_tx_en, smii_mode, tx_take, rx_stb, rx_crs;
   logic [7:0] line_tx_byte, rx_byte, rx_status;
   logic [8:0] got_q[$];    // {err, byte} seen on the line side
   int         miscompares = 0;
   int         n_compared  = 0;
   int         n;
   wire  [6:0] obs = {mii_tx_en, rmii_rx_valid, carrier_sense, line_tx_active,
                      rx_stb, line_tx_stb, tx_take};
   logic [8:0] tx_tab[4] = '{9'h0A5, 9'h13C, 9'h000, 9'h0FF};
   logic [7:0] rx_tab[4] = '{8'h5A, 8'h01, 8'h80, 8'hFE};

   smsi_if link ();
   smsi_phy u_smsi_phy (.mclk(mclk), .sys_rst(sys_rst), .link(link),
      .config_strap_2(straps[2]), .config_strap_1(straps[1]), .config_strap_0(straps[0]),
      .speed_10(speed_10), .line_rx_active(rx_act), .line_rx_byte(rx_in),
      .line_rx_stb(rx_in_stb), .line_tx_active(line_tx_active), .line_tx_byte(line_tx_byte),
      .line_tx_err(line_tx_err), .line_tx_stb(line_tx_stb), .carrier_sense(carrier_sense),
      .rmii_rx_valid(rmii_rx_valid), .mii_tx_en(mii_tx_en), .smii_mode(smii_mode));
   smsi_mac u_smsi_mac (.mclk(mclk), .sys_rst(sys_rst), .link(link), .speed_10(speed_10),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_err(tx_err), .tx_take(tx_take),
      .rx_byte(rx_byte), .rx_stb(rx_stb), .rx_crs(rx_crs), .rx_status(rx_status));
   smsi_monitor u_smsi_monitor (.mclk(mclk), .sys_rst(sys_rst),
      .serial_ref_clock(link.serial_ref_clock), .sync(link.sync), .txd(link.txd),
      .rxd(link.rxd));

   // core clock and a free-running link clock of unrelated phase
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      link.serial_ref_clock = 1'b0;
      #11;
      forever #80 link.serial_ref_clock = ~link.serial_ref_clock;
   end

   // collect decoded line bytes mid-cycle, where they are settled
   always @(negedge mclk) begin
      if (line_tx_stb === 1'b1) begin
         got_q.push_back({line_tx_err, line_tx_byte});
      end
   end

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic too_long(input string what);
      miscompares++;
      $display("MISMATCH %s expected done seen timeout", what);
      final_report();
   endtask : too_long

   task automatic chk_val(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_cnt(input string what, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_cnt

   // cycles until an observed output reads high, polled after each rising edge
   task automatic wait_obs(input int idx, input int lim, output int cyc);
      cyc = 0;
      while (obs[idx] !== 1'b1) begin
         @(posedge mclk);
         #1;
         cyc++;
         if (cyc > lim) begin
            too_long("output wait");
         end
      end
   endtask : wait_obs

   task automatic restart(input logic [2:0] code, input logic spd);
      sys_rst  = 1'b1;
      straps   = code;
      speed_10 = spd;
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      repeat (12) @(posedge mclk);
      #1;
   endtask : restart

   // offer a byte and hold it until taken; cyc counts cycles to the take
   task automatic send_tx(input logic [8:0] v, output int cyc);
      tx_err   = v[8];
      tx_byte  = v[7:0];
      tx_valid = 1'b1;
      cyc      = 0;
      do begin
         @(negedge mclk);
         cyc++;
      end while (tx_take !== 1'b1 && cyc < 2000);
      if (cyc >= 2000) begin
         too_long("tx take");
      end
      @(posedge mclk);
      #1;
   endtask : send_tx

   task automatic put_rx(input logic [7:0] b, input int lim);
      int cyc;
      rx_in     = b;
      rx_in_stb = 1'b1;
      @(posedge mclk);
      #1;
      rx_in_stb = 1'b0;
      wait_obs(2, lim, cyc);
      chk_val("rx byte", {1'b0, b}, {1'b0, rx_byte});
   endtask : put_rx

   task automatic check_line(input int cnt);
      for (int k = 0; k < 1000 && got_q.size() < cnt; k++) begin
         @(posedge mclk);
         #1;
      end
      chk_cnt("line byte count", cnt, cnt, got_q.size());
      for (int k = 0; k < cnt && k < got_q.size(); k++) begin
         chk_val("line byte", tx_tab[k], got_q[k]);
      end
      got_q.delete();
   endtask : check_line

   initial begin
      {straps, speed_10, rx_act, rx_in, rx_in_stb, tx_valid, tx_byte, tx_err} = '0;
      sys_rst = 1'b1;
      restart(3'h4, 1'b0);
      chk_val("serial mode", 9'h001, {8'h00, smii_mode});
      send_tx(tx_tab[0], n);
      tx_valid = 1'b0;
      wait_obs(1, 400, n);
      wait_obs(3, 40, n);
      chk_cnt("line tx latency", 11, 13, n);
      check_line(1);
      foreach (tx_tab[i]) begin
         send_tx(tx_tab[i], n);
         if (i > 0) chk_cnt("segment spacing", 78, 82, n);
      end
      tx_valid = 1'b0;
      check_line(4);
      chk_val("no tx-enable qualifier", 9'h000, {8'h00, mii_tx_en});
      rx_act = 1'b1;
      wait_obs(4, 40, n);
      chk_cnt("carrier latency", 13, 14, n);
      foreach (rx_tab[i]) put_rx(rx_tab[i], 400);
      chk_val("rx carrier", 9'h001, {8'h00, rx_crs});
      repeat (200) @(posedge mclk);
      #1;
      chk_val("status 100M", 9'h082, {1'b0, rx_status});
      rx_act = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      rx_act = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      chk_val("carrier short pulse", 9'h000, {8'h00, carrier_sense});
      rx_act = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      chk_val("carrier glitch", 9'h000, {8'h00, carrier_sense});
      restart(3'h4, 1'b1);
      put_rx(8'hC3, 2000);
      n = 0;
      repeat (1600) begin
         @(posedge mclk);
         #1;
         if (rx_stb === 1'b1) n++;
      end
      chk_cnt("repeated rx bytes", 0, 0, n);
      chk_val("status 10M", 9'h080, {1'b0, rx_status});
      send_tx(tx_tab[0], n);
      send_tx(tx_tab[1], n);
      tx_valid = 1'b0;
      chk_cnt("group spacing", 798, 802, n);
      check_line(2);
      restart(3'h2, 1'b0);
      chk_val("reduced-pin mode", 9'h000, {8'h00, smii_mode});
      rx_act = 1'b1;
      wait_obs(5, 40, n);
      chk_cnt("rx valid latency", 10, 11, n);
      restart(3'h0, 1'b0);
      chk_val("nibble mode", 9'h000, {8'h00, smii_mode});
      wait_obs(6, 200, n);
      final_report();
   end
endmodule : testbench
